//--- common/sau_defines.vh
// Constants for the stack arithmetic unit: register map, opcodes, flags
`ifndef SAU_DEFINES_VH
`define SAU_DEFINES_VH

// Register word offsets (byte addresses)
`define SAU_OFS_ACC 8'h00
`define SAU_OFS_STK1 8'h04
`define SAU_OFS_CMD 8'h08
`define SAU_OFS_FLAGS 8'h0C
`define SAU_OFS_DEPTH 8'h10

// Operation codes written to the command register
`define SAU_OP_BCD_DIV 3'h1
`define SAU_OP_BIN_ADD 3'h2
`define SAU_OP_BIN_SUB 3'h3
`define SAU_OP_BIN_MUL 3'h4
`define SAU_OP_BIN_DIV 3'h5

// Flag register bit positions
`define SAU_FLG_ZERO 0
`define SAU_FLG_NEG 1
`define SAU_FLG_LCARRY 2
`define SAU_FLG_FCARRY 3
`define SAU_FLG_LBORROW 4
`define SAU_FLG_FBORROW 5
`define SAU_FLG_SIGNERR 6
`define SAU_FLG_RANGE 7
`define SAU_FLG_INVBCD 8
`define SAU_FLG_W 9

// Stack geometry and divider length
`define SAU_STK_DEPTH 8
`define SAU_STK_DEPTH_VAL 32'h00000008
`define SAU_DIV_STEPS 6'h20
`define SAU_ACC_RST 32'h00000000
`define SAU_BCD_MAX_DIGIT 4'h9
`define SAU_BCD_DVD_DIGITS 4'h8
`define SAU_BCD_DVS_DIGITS 4'h4
`define SAU_DD_ADJ_MIN 4'h5
`define SAU_DD_ADJ 4'h3

`endif

//--- hw/sau_core.v
// Stack arithmetic unit: accumulator, stack, binary and BCD math, AHB slave
// Notes on behaviour
// - BCD divide: 8-digit accumulator by 4-digit level one; quotient, rest.
// - Both divides flag operand range when divisor exceeds usable size.
// - Zero flag follows whether the resulting accumulator is zero.
// - Negative flag follows the sign bit of the resulting accumulator.
// - BCD divide flags any accumulator nibble or low-four level-one nibble that is not a BCD digit.
// - A flag holds until a later operation affecting it overwrites it.
// - Binary add: accumulator plus level one into the accumulator.
// - Add, subtract, multiply pop level one and shift the stack up.
// - Low-half carry set on carry out of the low 16 bits.
// - Full-width carry set on carry out of bit 31.
// - Sign error set on signed overflow of add or subtract.
// - Binary subtract: accumulator minus level one into the accumulator.
// - Low-half borrow set when the low 16 bits need a borrow.
// - Full-width borrow set when the 32-bit subtraction needs a borrow.
// - Binary multiply: low 16 bits of both, 32-bit product to accumulator.
// - Binary divide: 32-bit accumulator by 16-bit level one; quotient, rest.
// - Loading the accumulator first pushes its old value onto level one.
`default_nettype none
`include "sau_defines.vh"

module sau_core (
   // Clock and reset
   input wire hclk,
   input wire hresetn,
   // AHB-Lite slave
   input wire hsel,
   input wire [31:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [2:0] hsize,
   input wire [31:0] hwdata,
   input wire hready,
   output wire hreadyout,
   output wire hresp,
   output wire [31:0] hrdata,
   // Status
   output wire op_busy
);

   localparam ST_IDLE = 2'b01;
   localparam ST_DIV = 2'b10;

   function [31:0] sau_bcd2bin;
      input [31:0] b;
      integer k;
      reg [31:0] r;
      begin
         r = 32'h00000000;
         for (k = 7; k >= 0; k = k - 1)
         begin
            r = (r << 3) + (r << 1) + {28'h0000000, b[4*k +: 4]};
         end
         sau_bcd2bin = r;
      end
   endfunction

   // Double dabble; input must be below 10^8 to fit eight digits
   function [31:0] sau_bin2bcd;
      input [31:0] v;
      integer k;
      integer j;
      reg [31:0] d;
      begin
         d = 32'h00000000;
         for (k = 31; k >= 0; k = k - 1)
         begin
            for (j = 0; j < 8; j = j + 1)
            begin
               if (d[4*j +: 4] >= `SAU_DD_ADJ_MIN)
                  d[4*j +: 4] = d[4*j +: 4] + `SAU_DD_ADJ;
            end
            d = {d[30:0], v[k]};
         end
         sau_bin2bcd = d;
      end
   endfunction

   function sau_bad_bcd;
      input [31:0] b;
      input [3:0] ndig;
      integer k;
      reg bad;
      begin
         bad = 1'b0;
         for (k = 0; k < 8; k = k + 1)
         begin
            if ((k < ndig) && (b[4*k +: 4] > `SAU_BCD_MAX_DIGIT))
               bad = 1'b1;
         end
         sau_bad_bcd = bad;
      end
   endfunction

   // Bus pipeline state
   reg act_ff;
   reg wr_ff;
   reg [7:0] addr_ff;
   reg rd_done_ff;
   reg [31:0] hrdata_ff;

   // Datapath state
   reg [31:0] acc_ff;
   reg [31:0] stk_ff [0:`SAU_STK_DEPTH-1];
   reg [`SAU_FLG_W-1:0] flags_ff;
   reg [1:0] state_ff;
   reg bcd_mode_ff;
   reg [31:0] quo_ff;
   reg [15:0] rem_ff;
   reg [15:0] dvs_ff;
   reg [5:0] cnt_ff;

   integer i;

   wire addr_phase = hsel & hready & htrans[1];
   wire wr_now = act_ff & wr_ff;
   wire busy = state_ff[1];
   wire [31:0] stk1 = stk_ff[0];

   assign hreadyout = ~(act_ff & ~wr_ff & ~rd_done_ff);
   assign hresp = 1'b0;
   assign hrdata = hrdata_ff;
   assign op_busy = busy;

   // Accepted register writes; ignored while a divide runs
   wire load_acc = wr_now & (addr_ff == `SAU_OFS_ACC) & ~busy;
   wire cmd_wr = wr_now & (addr_ff == `SAU_OFS_CMD) & ~busy;
   wire [2:0] op = hwdata[2:0];

   // Single-cycle results
   wire [16:0] nxt_lo_sum = {1'b0, acc_ff[15:0]} + {1'b0, stk1[15:0]};
   wire [32:0] nxt_sum = {1'b0, acc_ff} + {1'b0, stk1};
   wire [32:0] nxt_dif = {1'b0, acc_ff} - {1'b0, stk1};
   wire [31:0] nxt_prod = acc_ff[15:0] * stk1[15:0];

   // Divide operand checks
   wire [31:0] bcd_dvd = sau_bcd2bin(acc_ff);
   wire [31:0] bcd_dvs = sau_bcd2bin({16'h0000, stk1[15:0]});
   wire bad_bcd = sau_bad_bcd(acc_ff, `SAU_BCD_DVD_DIGITS) |
                  sau_bad_bcd(stk1, `SAU_BCD_DVS_DIGITS);
   wire div_big = |stk1[31:16];
   wire div_zero = ~(|stk1[15:0]);

   // Restoring divider step
   wire [16:0] trial = {rem_ff, quo_ff[31]};
   wire trial_ok = trial >= {1'b0, dvs_ff};
   wire [16:0] trial_sub = trial - {1'b0, dvs_ff};
   wire [15:0] nxt_rem = trial_ok ? trial_sub[15:0] : trial[15:0];
   wire [31:0] nxt_quo = {quo_ff[30:0], trial_ok};
   wire div_last = (cnt_ff == `SAU_DIV_STEPS - 6'h01);
   wire [31:0] nxt_acc_div = bcd_mode_ff ? sau_bin2bcd(nxt_quo) : nxt_quo;
   wire [31:0] nxt_stk_div = bcd_mode_ff ? sau_bin2bcd({16'h0000, nxt_rem})
                                         : {16'h0000, nxt_rem};

   // AHB address and data phase tracking
   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         act_ff <= 1'b0;
         wr_ff <= 1'b0;
         addr_ff <= 8'h00;
         rd_done_ff <= 1'b0;
      end
      else if (hreadyout)
      begin
         act_ff <= addr_phase;
         wr_ff <= hwrite;
         addr_ff <= {haddr[7:2], 2'b00};
         rd_done_ff <= 1'b0;
      end
      else
      begin
         rd_done_ff <= 1'b1;
      end
   end

   // Read data is sampled in the inserted wait cycle, so a write just
   // before it is already visible
   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         hrdata_ff <= 32'h00000000;
      else if (act_ff & ~wr_ff & ~rd_done_ff)
      begin
         case (addr_ff)
            `SAU_OFS_ACC: hrdata_ff <= acc_ff;
            `SAU_OFS_STK1: hrdata_ff <= stk1;
            `SAU_OFS_CMD: hrdata_ff <= {31'h00000000, busy};
            `SAU_OFS_FLAGS: hrdata_ff <= {23'h000000, flags_ff};
            `SAU_OFS_DEPTH: hrdata_ff <= `SAU_STK_DEPTH_VAL;
            default: hrdata_ff <= 32'h00000000;
         endcase
      end
   end

   // Accumulator, stack and divider sequencing
   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         acc_ff <= `SAU_ACC_RST;
         for (i = 0; i < `SAU_STK_DEPTH; i = i + 1)
            stk_ff[i] <= 32'h00000000;
         state_ff <= ST_IDLE;
         bcd_mode_ff <= 1'b0;
         quo_ff <= 32'h00000000;
         rem_ff <= 16'h0000;
         dvs_ff <= 16'h0000;
         cnt_ff <= 6'h00;
      end
      else
      begin
         case (state_ff)
            ST_IDLE:
            begin
               if (load_acc)
               begin
                  // Deepest entry falls off the bottom
                  for (i = `SAU_STK_DEPTH - 1; i > 0; i = i - 1)
                     stk_ff[i] <= stk_ff[i-1];
                  stk_ff[0] <= acc_ff;
                  acc_ff <= hwdata;
               end
               else if (cmd_wr)
               begin
                  case (op)
                     `SAU_OP_BIN_ADD,
                     `SAU_OP_BIN_SUB,
                     `SAU_OP_BIN_MUL:
                     begin
                        if (op == `SAU_OP_BIN_ADD)
                           acc_ff <= nxt_sum[31:0];
                        else if (op == `SAU_OP_BIN_SUB)
                           acc_ff <= nxt_dif[31:0];
                        else
                           acc_ff <= nxt_prod;
                        for (i = 0; i < `SAU_STK_DEPTH - 1; i = i + 1)
                           stk_ff[i] <= stk_ff[i+1];
                        stk_ff[`SAU_STK_DEPTH-1] <= 32'h00000000;
                     end
                     `SAU_OP_BCD_DIV:
                     begin
                        // Divisor zero, too wide or bad digit: no change
                        if (!(bad_bcd | div_big | div_zero))
                        begin
                           state_ff <= ST_DIV;
                           bcd_mode_ff <= 1'b1;
                           quo_ff <= bcd_dvd;
                           dvs_ff <= bcd_dvs[15:0];
                           rem_ff <= 16'h0000;
                           cnt_ff <= 6'h00;
                        end
                     end
                     `SAU_OP_BIN_DIV:
                     begin
                        if (!(div_big | div_zero))
                        begin
                           state_ff <= ST_DIV;
                           bcd_mode_ff <= 1'b0;
                           quo_ff <= acc_ff;
                           dvs_ff <= stk1[15:0];
                           rem_ff <= 16'h0000;
                           cnt_ff <= 6'h00;
                        end
                     end
                     default:
                     begin
                        state_ff <= ST_IDLE;
                     end
                  endcase
               end
            end
            ST_DIV:
            begin
               quo_ff <= nxt_quo;
               rem_ff <= nxt_rem;
               cnt_ff <= cnt_ff + 6'h01;
               if (div_last)
               begin
                  acc_ff <= nxt_acc_div;
                  stk_ff[0] <= nxt_stk_div;
                  state_ff <= ST_IDLE;
               end
            end
            default:
            begin
               state_ff <= ST_IDLE;
            end
         endcase
      end
   end

   // Status flags: each operation rewrites only the flags it owns
   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         flags_ff <= {`SAU_FLG_W{1'b0}};
      else if (state_ff[1] & div_last)
      begin
         flags_ff[`SAU_FLG_ZERO] <= ~(|nxt_acc_div);
         flags_ff[`SAU_FLG_NEG] <= nxt_acc_div[31];
         flags_ff[`SAU_FLG_RANGE] <= 1'b0;
         if (bcd_mode_ff)
            flags_ff[`SAU_FLG_INVBCD] <= 1'b0;
      end
      else if (cmd_wr)
      begin
         case (op)
            `SAU_OP_BIN_ADD:
            begin
               flags_ff[`SAU_FLG_ZERO] <= ~(|nxt_sum[31:0]);
               flags_ff[`SAU_FLG_NEG] <= nxt_sum[31];
               flags_ff[`SAU_FLG_LCARRY] <= nxt_lo_sum[16];
               flags_ff[`SAU_FLG_FCARRY] <= nxt_sum[32];
               flags_ff[`SAU_FLG_SIGNERR] <= (acc_ff[31] == stk1[31]) &
                  (nxt_sum[31] != acc_ff[31]);
            end
            `SAU_OP_BIN_SUB:
            begin
               flags_ff[`SAU_FLG_ZERO] <= ~(|nxt_dif[31:0]);
               flags_ff[`SAU_FLG_NEG] <= nxt_dif[31];
               flags_ff[`SAU_FLG_LBORROW] <=
                  acc_ff[15:0] < stk1[15:0];
               flags_ff[`SAU_FLG_FBORROW] <= nxt_dif[32];
               flags_ff[`SAU_FLG_SIGNERR] <= (acc_ff[31] != stk1[31]) &
                  (nxt_dif[31] != acc_ff[31]);
            end
            `SAU_OP_BIN_MUL:
            begin
               flags_ff[`SAU_FLG_ZERO] <= ~(|nxt_prod);
               flags_ff[`SAU_FLG_NEG] <= nxt_prod[31];
            end
            `SAU_OP_BCD_DIV:
            begin
               // Failing checks end the operation here; others wait
               flags_ff[`SAU_FLG_INVBCD] <= bad_bcd;
               flags_ff[`SAU_FLG_RANGE] <= div_big | div_zero;
            end
            `SAU_OP_BIN_DIV:
            begin
               flags_ff[`SAU_FLG_RANGE] <= div_big | div_zero;
            end
            default:
            begin
               flags_ff <= flags_ff;
            end
         endcase
      end
   end

endmodule // sau_core
`default_nettype wire

//--- testbench/sau_core_sva.sv
// Bus timing and divide-length checker for the stack arithmetic unit
`default_nettype none
`include "sau_defines.vh"
module sau_core_sva (
   // Clock and reset
   input wire hclk,
   input wire hresetn,
   // Bus
   input wire hsel,
   input wire [31:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire hready,
   input wire hreadyout,
   input wire hresp,
   input wire [31:0] hrdata,
   // Status
   input wire op_busy
);
   timeunit 1ns;
   timeprecision 1ns;
   logic rd_dp_ff;
   logic cmd_dp_ff;
   logic [5:0] bsy_cnt_ff;
   wire take = hsel & hready & htrans[1];
   wire rd_take = take & ~hwrite;
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         rd_dp_ff <= 1'b0;
         cmd_dp_ff <= 1'b0;
         bsy_cnt_ff <= 6'h00;
      end
      else
      begin
         if (hready)
         begin
            rd_dp_ff <= rd_take;
            cmd_dp_ff <= take & hwrite &
               ({haddr[7:2], 2'b00} == `SAU_OFS_CMD);
         end
         bsy_cnt_ff <= op_busy ? bsy_cnt_ff + 6'h01 : 6'h00;
      end
   end
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   a_resp_okay: assert property (hresp == 1'b0)
      else $error("error response seen");
   a_read_wait: assert property (rd_take |=> !hreadyout ##1 hreadyout)
      else $error("read data phase not one wait state");
   a_write_nowait: assert property (take & hwrite |=> hreadyout)
      else $error("write data phase stalled");
   a_wait_cause: assert property (!hreadyout |-> rd_dp_ff)
      else $error("wait state outside a read");
   a_rdata_hold: assert property (!$stable(hrdata) |-> !$past(hreadyout))
      else $error("read data changed outside a wait state");
   a_depth_read: assert property (rd_take &&
      {haddr[7:2], 2'b00} == `SAU_OFS_DEPTH
      |-> ##2 hrdata == `SAU_STK_DEPTH_VAL)
      else $error("depth register wrong");
   a_unmapped_zero: assert property (rd_take &&
      {haddr[7:2], 2'b00} > `SAU_OFS_DEPTH
      |-> ##2 hrdata == 32'h00000000)
      else $error("unmapped read not zero");
   a_busy_start: assert property ($rose(op_busy) |-> $past(cmd_dp_ff))
      else $error("busy rose without a command write");
   a_busy_length: assert property ($fell(op_busy) |-> bsy_cnt_ff == `SAU_DIV_STEPS)
      else $error("divide length wrong");
   a_busy_bound: assert property (bsy_cnt_ff <= `SAU_DIV_STEPS)
      else $error("divide overran");
   c_read: cover property (rd_take ##2 hreadyout);
   c_write: cover property (take & hwrite);
   c_divide: cover property ($fell(op_busy));
endmodule // sau_core_sva

bind sau_core sau_core_sva u_sva (.hclk(hclk), .hresetn(hresetn),
   .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
   .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
   .hrdata(hrdata), .op_busy(op_busy));
`default_nettype wire

//--- testbench/sau_seq_model.sv
// Instruction sequencer model: single-word bus master for the unit
`default_nettype none
`include "sau_defines.vh"
module sau_seq_model (
   // Clock
   input wire logic hclk,
   // Bus
   output logic hsel,
   output logic [31:0] haddr,
   output logic [1:0] htrans,
   output logic hwrite,
   output logic [2:0] hsize,
   output logic [31:0] hwdata,
   input wire logic hready,
   input wire logic [31:0] hrdata
);
   timeunit 1ns;
   timeprecision 1ns;
   initial
   begin
      hsel = 1'b0;
      haddr = 32'h00000000;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h00000000;
   end
   // Released lines carry inverted data so stale values never pass
   task xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] q);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= {24'h000000, a};
      hwrite <= w;
      htrans <= 2'h2;
      do @(posedge hclk); while (hready !== 1'b1);
      htrans <= 2'h0;
      haddr <= ~{24'h000000, a};
      hwdata <= d;
      do @(posedge hclk); while (hready !== 1'b1);
      q = hrdata;
      hwdata <= ~d;
   endtask
   task bus_wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      xfer(1'b1, a, d, q);
   endtask
   task bus_rd(input logic [7:0] a, output logic [31:0] q);
      xfer(1'b0, a, 32'h00000000, q);
   endtask
   task load(input logic [31:0] v);
      bus_wr(`SAU_OFS_ACC, v);
   endtask
endmodule // sau_seq_model
`default_nettype wire

//--- testbench/stack_arith_unit_tb.sv
// Self-checking testbench for the stack arithmetic unit
`default_nettype none
`include "sau_defines.vh"
module stack_arith_unit_tb;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [2:0] ADD = `SAU_OP_BIN_ADD, SUB = `SAU_OP_BIN_SUB,
      MUL = `SAU_OP_BIN_MUL, DIVB = `SAU_OP_BIN_DIV, DIVD = `SAU_OP_BCD_DIV;
   localparam logic [8:0] Z = 9'h001 << `SAU_FLG_ZERO,
      N = 9'h001 << `SAU_FLG_NEG, LC = 9'h001 << `SAU_FLG_LCARRY,
      FC = 9'h001 << `SAU_FLG_FCARRY, LB = 9'h001 << `SAU_FLG_LBORROW,
      FB = 9'h001 << `SAU_FLG_FBORROW, SE = 9'h001 << `SAU_FLG_SIGNERR,
      RG = 9'h001 << `SAU_FLG_RANGE, IB = 9'h001 << `SAU_FLG_INVBCD;
   localparam logic [8:0] MA = Z|N|LC|FC|SE, MS = Z|N|LB|FB|SE, MM = Z|N,
      MB = RG|Z|N, MD = MB|IB, MX = RG|IB;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   wire hsel;
   wire [31:0] haddr;
   wire [1:0] htrans;
   wire hwrite;
   wire [2:0] hsize;
   wire [31:0] hwdata;
   wire hreadyout;
   wire hresp;
   wire [31:0] hrdata;
   wire op_busy;
   int err_total = 0;
   int cmp_count = 0;
   int i;
   logic [8:0] exp_flg = 9'h000;
   logic [31:0] prv = 32'h00000022;
   always #50 hclk = ~hclk;
   sau_core dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
      .hrdata(hrdata), .op_busy(op_busy));
   sau_seq_model u_seq (.hclk(hclk), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hrdata(hrdata));
   task cmp(input logic [31:0] g, input logic [31:0] e);
      cmp_count++;
      if (g !== e)
      begin
         err_total++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task chk(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] q;
      u_seq.bus_rd(a, q);
      cmp(q, e);
   endtask
   // Divides hold busy; poll off the edge to avoid racing its update
   task wait_idle;
      int n;
      @(negedge hclk);
      for (n = 0; n < 40 && op_busy !== 1'b0; n++) @(negedge hclk);
      cmp({31'h00000000, op_busy}, 32'h00000000);
   endtask
   task run(input logic [2:0] op, input logic [31:0] s, input logic [31:0] a,
      input logic [31:0] ea, input logic [31:0] es, input logic [8:0] f,
      input logic [8:0] m);
      u_seq.load(s);
      u_seq.load(a);
      u_seq.bus_wr(`SAU_OFS_CMD, {29'h00000000, op});
      wait_idle;
      exp_flg = (exp_flg & ~m) | f;
      prv = ea;
      chk(`SAU_OFS_ACC, ea);
      chk(`SAU_OFS_STK1, es);
      chk(`SAU_OFS_FLAGS, {23'h000000, exp_flg});
   endtask
   task end_of_test;
      $display("Comparisons %0d, mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   initial
   begin
      repeat (20000) @(posedge hclk);
      err_total++;
      end_of_test;
   end
   initial
   begin
      repeat (12) @(posedge hclk);
      hresetn <= 1'b1;
      chk(`SAU_OFS_ACC, `SAU_ACC_RST);
      chk(`SAU_OFS_FLAGS, 32'h00000000);
      chk(`SAU_OFS_DEPTH, `SAU_STK_DEPTH_VAL);
      u_seq.bus_wr(8'h14, 32'hA5A5A5A5);
      u_seq.bus_wr(`SAU_OFS_STK1, 32'h5A5A5A5A);
      chk(8'h14, 32'h00000000);
      chk(`SAU_OFS_STK1, 32'h00000000);
      u_seq.load(32'h11);
      u_seq.load(32'h22);
      chk(`SAU_OFS_STK1, 32'h11);
      // Undefined opcodes must leave data and flags alone
      u_seq.bus_wr(`SAU_OFS_CMD, 32'h00000000);
      u_seq.bus_wr(`SAU_OFS_CMD, 32'h00000007);
      chk(`SAU_OFS_ACC, 32'h22);
      chk(`SAU_OFS_STK1, 32'h11);
      chk(`SAU_OFS_FLAGS, 32'h00000000);
      run(ADD, 32'hFFFF, 32'h1, 32'h10000, prv, LC, MA);
      run(ADD, 32'hFFFFFFFF, 32'h1, 32'h0, prv, Z|LC|FC, MA);
      run(ADD, 32'h1, 32'h7FFFFFFF, 32'h80000000, prv, N|LC|SE, MA);
      run(SUB, 32'h1, 32'h10000, 32'hFFFF, prv, LB, MS);
      run(SUB, 32'h1, 32'h0, 32'hFFFFFFFF, prv, N|LB|FB, MS);
      run(SUB, 32'h5, 32'h5, 32'h0, prv, Z, MS);
      run(SUB, 32'h1, 32'h80000000, 32'h7FFFFFFF, prv, LB|SE, MS);
      run(MUL, 32'h5FFFF, 32'h1234FFFF, 32'hFFFE0001, prv, N, MM);
      run(MUL, 32'h3, 32'h0, 32'h0, prv, Z, MM);
      run(DIVB, 32'h7, 32'h64, 32'hE, 32'h2, 9'h000, MB);
      run(DIVB, 32'hFFFF, 32'hFFFFFFFF, 32'h10001, 32'h0, 9'h000, MB);
      run(DIVB, 32'h0, 32'h5, 32'h5, 32'h0, RG, RG);
      run(DIVB, 32'h10000, 32'h5, 32'h5, 32'h10000, RG, RG);
      run(DIVD, 32'h7, 32'h100, 32'h14, 32'h2, 9'h000, MD);
      run(DIVD, 32'h1, 32'h99999999, 32'h99999999, 32'h0, N, MD);
      run(DIVD, 32'h1234, 32'h99999999, 32'h81037, 32'h341, 9'h000, MD);
      run(DIVD, 32'hA, 32'h5, 32'h5, 32'hA, IB, MX);
      run(DIVD, 32'h1, 32'h1F, 32'h1F, 32'h1, IB, MX);
      run(DIVD, 32'h10000, 32'h5, 32'h5, 32'h10000, RG, MX);
      run(DIVD, 32'h0, 32'h5, 32'h5, 32'h0, RG, MX);
      for (i = 1; i <= 9; i++) u_seq.load(i);
      for (i = 1; i <= 8; i++) u_seq.bus_wr(`SAU_OFS_CMD, {29'h0, ADD});
      exp_flg = exp_flg & ~MA;
      chk(`SAU_OFS_ACC, 32'h2D);
      chk(`SAU_OFS_STK1, 32'h0);
      u_seq.load(32'h9);
      u_seq.bus_wr(`SAU_OFS_CMD, {29'h0, DIVB});
      chk(`SAU_OFS_CMD, 32'h1);
      u_seq.load(32'h55);
      u_seq.bus_wr(`SAU_OFS_CMD, {29'h0, ADD});
      wait_idle;
      exp_flg = (exp_flg & ~MB) | Z;
      chk(`SAU_OFS_ACC, 32'h0);
      chk(`SAU_OFS_STK1, 32'h9);
      chk(`SAU_OFS_FLAGS, {23'h0, exp_flg});
      end_of_test;
   end
endmodule // stack_arith_unit_tb
`default_nettype wire
